// >>> core/ee2w_pkg.sv
// Purpose: shared constants for the two-wire serial eeprom target
// Assumes: system clock of 25 MHz
// Notes:   times kept in their own unit, cycle counts derived here
package ee2w_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ                   = 25000000;
  localparam int unsigned INTERNAL_PROGRAM_TIME_US = 5000;
  // longest time, so round down
  localparam int unsigned PROG_CYCLES =
    (INTERNAL_PROGRAM_TIME_US * (CLK_HZ / 1000000));
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 11;
  localparam int unsigned PAGE_W    = 4;
  localparam int unsigned MEM_DEPTH = 2048;
  localparam int unsigned SN_BYTES  = 16;
  // ----------------------------------------------------------------
  // address byte
  // ----------------------------------------------------------------
  localparam logic [3:0] ARRAY_CODE  = 4'hA;
  localparam logic [3:0] SERIAL_CODE = 4'hB;
  localparam logic [2:0] SERIAL_PAGE = 3'h0;
  // arbitrary value, replaced per part at manufacture
  localparam logic [127:0] SERIAL_NUMBER = 128'h0123456789ABCDEF0F1E2D3C4B5A6978;
  // ----------------------------------------------------------------
  // protocol states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DEV   = 3'b001,
    ST_WADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_RACK  = 3'b101
  } ee2w_state_t;
endpackage

// >>> core/ee2w_mem.sv
// Purpose: byte array of the eeprom with registered read data
// Assumes: one write and one read per clock
// Notes:   read data valid one cycle after the address
`timescale 1ns/100ps
module ee2w_mem #(
  parameter int unsigned AW = 11,
  parameter int unsigned DW = 8
) (
  // clock
  input  wire logic          clk,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // no reset: contents are nonvolatile in intent
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// >>> core/ee2w_slave.sv
// Purpose: two-wire target of a 2 KiB serial eeprom with serial number
// Assumes: scl, sda_i and write_protect are asynchronous pins
// Notes:   page bytes are buffered then programmed after the stop
`timescale 1ns/100ps
// Function
// R1 - sample sda on rising scl
// R2 - change driven sda after falling scl
// R3 - sda open drain: pull low or release
// R4 - fixed address match, no address pins
// R5 - write protect high blocks array writes
// R6 - write protect low allows reads, writes
// R7 - 128 pages of 16 bytes, 11-bit address
// R8 - page write up to 16, partial allowed
// R9 - self-timed programming, at most 5 ms
// R10 - separate 128-bit serial number area
// R11 - serial number is read only
// R12 - controller keeps scl within rate limit
// R13 - start and stop while scl high
// R14 - 8-bit words, ack on ninth clock
// R15 - array address byte 1010 ppp rw
// R16 - serial area address byte 1011 000
// R17 - no ack while programming runs
// R18 - page write wraps lowest four bits
module ee2w_slave
  import ee2w_pkg::*;
#(
  parameter int unsigned PROG_COUNT = PROG_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // two-wire pins
  input  wire logic scl,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  // protection and status
  input  wire logic write_protect,
  output logic      busy
);
  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_reg, sda_sync_reg, wp_sync_reg;
  logic       scl_d_reg, sda_d_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      wp_sync_reg  <= 2'h0;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      wp_sync_reg  <= {wp_sync_reg[0], write_protect};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end
  logic scl_s, sda_s, wp_s, scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_s    = scl_sync_reg[1];
  assign sda_s    = sda_sync_reg[1];
  assign wp_s     = wp_sync_reg[1];
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  // start and stop only while scl stays high
  assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s; // R13
  assign stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s; // R13

  // ----------------------------------------------------------------
  // protocol state
  // ----------------------------------------------------------------
  ee2w_state_t       state_reg, state_next;
  logic [3:0]        bit_reg, bit_next;       // 0..7 data, 8 ack slot
  logic [7:0]        shift_reg, shift_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [3:0]        sn_ptr_reg, sn_ptr_next;
  logic              sn_sel_reg, sn_sel_next;
  logic              drive_reg, drive_next;   // pulls sda low when set
  logic              nack_reg, nack_next;     // master nacked read
  logic [7:0]        pbuf_reg [SN_BYTES];
  logic [15:0]       pval_reg, pval_next;     // page bytes pending
  logic              pwe;
  logic [3:0]        pidx;
  logic [22:0]       prog_cnt_reg, prog_cnt_next;
  logic [3:0]        flush_reg, flush_next;
  logic              flushing_reg, flushing_next;
  logic [7:0]        mem_rd;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0]        rd_byte;                 // byte to shift out next

  // byte of the serial number at a given pointer
  function automatic logic [7:0] sn_byte(input logic [3:0] p); // R10
    sn_byte = SERIAL_NUMBER[8'(127 - 8*p) -: 8];
  endfunction

  // address byte decode: 1 array, 2 serial area, 0 no match
  function automatic logic [1:0] dev_match(input logic [7:0] b);
    if (b[7:4] == ARRAY_CODE)                                  dev_match = 2'h1; // R15 R4
    else if (b[7:4] == SERIAL_CODE && b[3:1] == SERIAL_PAGE)   dev_match = 2'h2; // R16
    else                                                       dev_match = 2'h0;
  endfunction

  assign busy = flushing_reg | (prog_cnt_reg != 23'h0);
  assign rd_byte = sn_sel_reg ? sn_byte(sn_ptr_reg) : mem_rd;

  // next-state logic of the bus engine
  always_comb begin
    state_next    = state_reg;
    bit_next      = bit_reg;
    shift_next    = shift_reg;
    addr_next     = addr_reg;
    sn_ptr_next   = sn_ptr_reg;
    sn_sel_next   = sn_sel_reg;
    drive_next    = drive_reg;
    nack_next     = nack_reg;
    pval_next     = pval_reg;
    pwe           = 1'b0;
    pidx          = addr_reg[PAGE_W-1:0];
    prog_cnt_next = (prog_cnt_reg != 23'h0) ? prog_cnt_reg - 23'h1 : 23'h0; // R9
    flush_next    = flush_reg;
    flushing_next = flushing_reg;
    // flush pending page bytes one per clock, then time the program
    if (flushing_reg) begin
      pval_next[flush_reg] = 1'b0;
      flush_next = flush_reg + 4'h1;
      if (flush_reg == 4'hF) begin
        flushing_next = 1'b0;
        prog_cnt_next = 23'(PROG_COUNT); // R9
      end
    end
    if (start_ev) begin
      state_next = ST_DEV;
      // one below zero: the scl fall that closes the start is not a bit
      bit_next   = 4'hF;
      drive_next = 1'b0;
    end else if (stop_ev) begin
      state_next = ST_IDLE;
      drive_next = 1'b0;
      // any array byte accepted while unprotected starts a program cycle
      if (pval_reg != 16'h0 && !busy) begin
        flushing_next = 1'b1; // R9
        flush_next    = 4'h0;
      end
    end else if (state_reg != ST_IDLE) begin
      // no shift while sending: shift_reg holds the outgoing byte
      if (scl_rise && bit_reg < 4'h8 && state_reg != ST_RACK) begin
        shift_next = {shift_reg[6:0], sda_s}; // R1
      end else if (scl_rise && bit_reg == 4'h8 && state_reg == ST_RACK) begin
        nack_next = sda_s;
      end
      if (scl_fall) begin // R2
        bit_next   = bit_reg + 4'h1;
        drive_next = 1'b0;
        if (bit_reg == 4'h7 && state_reg != ST_RACK) begin
          // eighth bit in: decide on the ack for ninth clock
          case (state_reg)
            ST_DEV: begin
              if (dev_match(shift_reg) != 2'h0 && !busy) begin // R17
                drive_next  = 1'b1; // R14
                sn_sel_next = (dev_match(shift_reg) == 2'h2);
                if (dev_match(shift_reg) == 2'h1) begin
                  addr_next[10:8] = shift_reg[3:1];
                end
                state_next = shift_reg[0] ? ST_RDATA : ST_WADDR;
              end else begin
                state_next = ST_IDLE;
              end
            end
            ST_WADDR: begin
              drive_next = 1'b1; // R14
              if (sn_sel_reg) sn_ptr_next = shift_reg[3:0];
              else            addr_next[7:0] = shift_reg;
              state_next = ST_WDATA;
            end
            ST_WDATA: begin
              drive_next = 1'b1; // R14 R8
              if (!sn_sel_reg && !wp_s) begin // R5 R6 R11
                pwe              = 1'b1;
                pval_next[pidx]  = 1'b1;
              end
              addr_next[PAGE_W-1:0] = addr_reg[PAGE_W-1:0] + 4'h1; // R18
            end
            default: state_next = state_reg;
          endcase
        end else if (bit_reg == 4'h8) begin
          bit_next = 4'h0;
          if (state_reg == ST_RDATA) begin
            state_next = ST_RACK;
            drive_next = ~rd_byte[7];
            shift_next = rd_byte;
          end else if (state_reg == ST_RACK) begin
            if (nack_reg) begin
              state_next = ST_IDLE;
            end else begin
              drive_next = ~rd_byte[7];
              shift_next = rd_byte;
            end
          end
        end else if (state_reg == ST_RACK && bit_reg < 4'h7) begin
          drive_next = ~shift_reg[6 - 3'(bit_reg)];
        end else if (state_reg == ST_RACK && bit_reg == 4'h7) begin
          // release for master ack, step the read pointer
          if (sn_sel_reg) sn_ptr_next = sn_ptr_reg + 4'h1;
          else            addr_next   = addr_reg + 11'h1;
        end
      end
    end
  end

  // registers of the bus engine
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= ST_IDLE;
      bit_reg      <= 4'h0;
      shift_reg    <= 8'h00;
      addr_reg     <= '0;
      sn_ptr_reg   <= 4'h0;
      sn_sel_reg   <= 1'b0;
      drive_reg    <= 1'b0;
      nack_reg     <= 1'b0;
      pval_reg     <= 16'h0;
      prog_cnt_reg <= 23'h0;
      flush_reg    <= 4'h0;
      flushing_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      bit_reg      <= bit_next;
      shift_reg    <= shift_next;
      addr_reg     <= addr_next;
      sn_ptr_reg   <= sn_ptr_next;
      sn_sel_reg   <= sn_sel_next;
      drive_reg    <= drive_next;
      nack_reg     <= nack_next;
      pval_reg     <= pval_next;
      prog_cnt_reg <= prog_cnt_next;
      flush_reg    <= flush_next;
      flushing_reg <= flushing_next;
    end
  end

  // page buffer: holds bytes until the stop; bytes of a write cut off by a start wait for the next stop
  always_ff @(posedge clk) begin
    if (pwe) pbuf_reg[pidx] <= shift_reg;
  end

  // ----------------------------------------------------------------
  // array and pins
  // ----------------------------------------------------------------
  assign mem_we = flushing_reg & pval_reg[flush_reg];
  assign mem_wa = {addr_reg[ADDR_W-1:PAGE_W], flush_reg};
  ee2w_mem #(.AW(ADDR_W), .DW(8)) u_mem ( // R7
    .clk     (clk),
    .wr_en   (mem_we),
    .wr_addr (mem_wa),
    .wr_data (pbuf_reg[flush_reg]),
    .rd_addr (addr_reg),
    .rd_data (mem_rd)
  );

  // open drain: output always low, enable only pulls
  assign sda_o  = 1'b0;      // R3
  assign sda_oe = drive_reg; // R3

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_busy_no_ack: assert property (@(posedge clk) disable iff (!rstn) // R17
    (busy && state_reg == ST_DEV && scl_fall && bit_reg == 4'h7 && !start_ev && !stop_ev)
      |=> !drive_reg)
    else $error("ack given while programming");
  chk_sda_on_fall: assert property (@(posedge clk) disable iff (!rstn) // R2
    $rose(drive_reg) |-> $past(scl_fall) || $past(start_ev))
    else $error("sda pulled low outside falling scl");
  chk_wp_blocks: assert property (@(posedge clk) disable iff (!rstn) // R5
    pwe |-> !wp_s && !sn_sel_reg)
    else $error("array byte taken under write protect");
  chk_prog_time: assert property (@(posedge clk) disable iff (!rstn) // R9
    (prog_cnt_reg != 23'h0) |-> prog_cnt_reg <= 23'(PROG_COUNT))
    else $error("program time exceeds limit");
  chk_page_wrap: assert property (@(posedge clk) disable iff (!rstn) // R18
    pwe |=> addr_reg[10:4] == $past(addr_reg[10:4]))
    else $error("page write left its page");
  chk_ack_ninth: assert property (@(posedge clk) disable iff (!rstn) // R14
    (scl_fall && bit_reg == 4'h8 && state_reg != ST_RDATA && state_reg != ST_RACK
      && !start_ev && !stop_ev) |=> !drive_reg)
    else $error("ack held past ninth clock");
  chk_stop_idle: assert property (@(posedge clk) disable iff (!rstn) // R13
    stop_ev && !start_ev |=> state_reg == ST_IDLE && !drive_reg)
    else $error("stop did not release bus");
  chk_oe_only: assert property (@(posedge clk) disable iff (!rstn) // R3
    sda_o == 1'b0)
    else $error("sda driven high");
endmodule

// >>> dv/ee2w_ctrl_model.sv
// Purpose: behavioural two-wire bus controller facing the eeprom target
// Assumes: sda wire level fed back on sda_i, pull-up on the wire
// Notes:   scl period 8 clk (320 ns); scl idles high between frames
`timescale 1ns/100ps
module ee2w_ctrl_model (
  // clock
  input  wire logic clk,
  // bus pins
  input  wire logic sda_i,
  output logic      scl,
  output logic      sda_pull
);
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  // wait n clocks, then step off the edge
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one bit: sda moves a clock after scl falls, so no false start or stop
  task automatic send_bit(input logic v, output logic s);
    tk(1);
    sda_pull = ~v;
    tk(3);
    scl = 1'b1;
    tk(2);
    s = sda_i; // mid-high sample, clear of the target's output lag
    tk(2);
    scl = 1'b0;
  endtask
  // start or repeated start: sda falls while scl is high
  task automatic start();
    tk(1);
    sda_pull = 1'b0;
    tk(3);
    scl = 1'b1;
    tk(2);
    sda_pull = 1'b1;
    tk(2);
    scl = 1'b0;
  endtask
  // stop: sda rises while scl is high, bus left idle
  task automatic stop();
    tk(1);
    sda_pull = 1'b1;
    tk(3);
    scl = 1'b1;
    tk(2);
    sda_pull = 1'b0;
    tk(2);
  endtask
  // byte out msb first; ack is 1 when the target pulled sda low
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) send_bit(b[i], s);
    send_bit(1'b1, s);
    ack = ~s;
  endtask
  // byte in; last gives the nack that ends a read
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      send_bit(1'b1, s);
      b[i] = s;
    end
    send_bit(last, s);
  endtask
endmodule

// >>> dv/ee2w_slave_tb_top.sv
// Purpose: self-checking bench for the two-wire eeprom target
// Assumes: controller model on the far side, pull-up on sda
// Notes:   program time shortened to PROG_N clocks to keep runs short
`timescale 1ns/100ps
module ee2w_slave_tb_top
  import ee2w_pkg::*;
;
  localparam int PROG_N = 500;
  logic clk;
  logic rstn;
  logic scl;
  logic sda_pull;
  logic sda;
  logic sda_o;
  logic sda_oe;
  logic write_protect;
  logic busy;
  int   err_total;
  int   n_checks;
  // wired-and data line with pull-up
  assign sda = ~(sda_pull | (sda_oe & ~sda_o));
  ee2w_slave #(.PROG_COUNT(PROG_N)) dut (
    .clk(clk), .rstn(rstn), .scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .write_protect(write_protect), .busy(busy));
  ee2w_ctrl_model m (.clk(clk), .sda_i(sda), .scl(scl), .sda_pull(sda_pull));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // open drain: whenever driven, the level is low
  // looked at mid-cycle, clear of the edge that launches sda_oe
  always @(negedge clk) if (sda_oe === 1'b1) check({7'h00, sda_o}, 8'h00);
  // send a byte and judge the ninth-clock answer
  task automatic tx(input logic [7:0] b, input logic exp_ack);
    logic a;
    m.wbyte(b, a);
    check({7'h00, a}, {7'h00, exp_ack});
  endtask
  // wait for the program cycle to end; lo is the least wait expected
  task automatic wait_idle(input int lo);
    int n;
    n = 0;
    // busy rises only once the stop has passed the pin synchronisers
    m.tk(2);
    while (busy !== 1'b0 && n < 4000) begin
      m.tk(1);
      n++;
    end
    check({7'h00, n >= lo && n <= PROG_N + 40}, 8'h01);
    if (n >= 4000) tally_and_finish();
  endtask
  // dummy write of the pointer, repeated start, sequential read
  task automatic rd_cmp(input logic [7:0] dev, input logic [7:0] ptr, input int cnt,
                        input logic [7:0] exp [16]);
    logic [7:0] d;
    m.start();
    tx(dev, 1'b1);
    tx(ptr, 1'b1);
    m.start();
    tx(dev | 8'h01, 1'b1);
    for (int i = 0; i < cnt; i++) begin
      m.rbyte(i == cnt - 1, d);
      check(d, exp[i]);
    end
    m.stop();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // byte write at 0x5A3, poll refused while busy, read back
  task automatic s_byte();
    logic [7:0] e [16];
    e[0] = 8'h3C;
    m.start();
    tx(8'hAA, 1'b1);
    tx(8'hA3, 1'b1);
    tx(8'h3C, 1'b1);
    m.stop();
    m.tk(3);
    check({7'h00, busy}, 8'h01);
    m.start();
    tx(8'hAA, 1'b0);
    m.stop();
    wait_idle(PROG_N - 120);
    rd_cmp(8'hAA, 8'hA3, 1, e);
  endtask
  // 18 bytes from offset 14 of page 0x120: wraps and overwrites
  task automatic s_page();
    logic [7:0] e [16];
    m.start();
    tx(8'hA2, 1'b1);
    tx(8'h2E, 1'b1);
    for (int i = 0; i < 18; i++) tx(8'(8'h40 + i), 1'b1);
    m.stop();
    wait_idle(PROG_N);
    for (int o = 0; o < 16; o++) e[o] = 8'(8'h42 + o);
    rd_cmp(8'hA2, 8'h20, 16, e);
  endtask
  // protected write is taken but leaves the array alone
  task automatic s_wp();
    logic [7:0] e [16];
    e[0] = 8'h3C;
    write_protect = 1'b1;
    m.start();
    tx(8'hAA, 1'b1);
    tx(8'hA3, 1'b1);
    tx(8'hFF, 1'b1);
    m.stop();
    wait_idle(0);
    rd_cmp(8'hAA, 8'hA3, 1, e);
    write_protect = 1'b0;
  endtask
  // serial area: write attempt ignored, 16 bytes read msb byte first
  task automatic s_serial();
    logic [7:0] e [16];
    m.start();
    tx(8'hB0, 1'b1);
    tx(8'h00, 1'b1);
    tx(8'h55, 1'b1);
    m.stop();
    wait_idle(0);
    for (int k = 0; k < 16; k++) e[k] = SERIAL_NUMBER[127 - 8 * k -: 8];
    rd_cmp(8'hB0, 8'h00, 16, e);
  endtask
  // foreign address bytes get no answer
  task automatic s_bad();
    logic [7:0] bad [3] = '{8'h90, 8'hB2, 8'hCA};
    for (int i = 0; i < 3; i++) begin
      m.start();
      tx(bad[i], 1'b0);
      m.stop();
    end
  endtask
  initial begin
    err_total = 0;
    n_checks = 0;
    rstn = 1'b0;
    write_protect = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    m.tk(4);
    s_byte();
    s_page();
    s_wp();
    s_serial();
    s_bad();
    tally_and_finish();
  end
endmodule
